// [hw/nested_interrupt_vector_router.sv]
// Nested vector controller with per-vector source routing
// What this block does
// - Handles 16 system exception numbers and 32 peripheral interrupts.
// - Word at vector offset zero loads the main stack pointer.
// - Reset, NMI, hard fault fixed -3,-2,-1; blocked faults escalate.
// - Memory, bus, usage faults programmable; bus errors raise bus fault.
// - Call, pended service, tick, debug programmable; 7-10, 13 reserved.
// - Peripheral n is exception n+16, vector at 0x40 plus 4n.
// - NMI comes from any selected pin or is disconnected.
// - Eight peripheral priority levels, changeable at run time.
// - Grouping splits priority; only group part decides preemption.
// - Tail-chain pending interrupts at exit; late arrival wins stacking.
// - Hardware saves state on entry and restores on exit.
// - Equal priority: lower vector number served first.
// - Each vector selects fixed, DMA or array source.
// - Vectors 0-15 use low DMA done bus, 16-31 high bus.
// - Vector n may take array interrupt bit n.
// - Array routing is fixed: array bit n can reach only vector n.
// - Fixed lines per vector; vectors 2,14,16,26,28 have none.
`include "nvr_map.svh"
module nested_interrupt_vector_router #(
	parameter int PIN_COUNT  = 64,
	parameter int NEST_DEPTH = 12,
	parameter int PSW        = $clog2(PIN_COUNT),
	parameter int SPW        = $clog2(NEST_DEPTH + 1)
) (
	input  wire logic            REF_CLK_I,
	input  wire logic            RESET_I,
	input  wire logic            CLK_EN_I,
	input  wire logic [31:0]     FIXED_IRQ_I,
	input  wire logic [15:0]     DMA_DONE_BUS_LOW_I,
	input  wire logic [15:0]     DMA_DONE_BUS_HIGH_I,
	input  wire logic [31:0]     ARRAY_IRQ_I,
	input  wire logic [63:0]     SRC_SEL_I,
	input  wire logic [31:0]     IRQ_ENABLE_I,
	input  wire logic [95:0]     IRQ_PRIO_I,
	input  wire logic [20:0]     SYS_PRIO_I,
	input  wire logic [1:0]      GROUP_SPLIT_I,
	input  wire logic [PIN_COUNT-1:0] PIN_I,
	input  wire logic            NMI_CONNECT_I,
	input  wire logic [PSW-1:0]  NMI_PIN_SEL_I,
	input  wire logic            MEM_FAULT_I,
	input  wire logic            BUS_ERROR_I,
	input  wire logic            USAGE_FAULT_I,
	input  wire logic [2:0]      FAULT_EN_I,
	input  wire logic            SUPERVISOR_CALL_I,
	input  wire logic            DEBUG_MON_I,
	input  wire logic            PENDED_SERVICE_I,
	input  wire logic            SYSTEM_TICK_I,
	output logic                 VEC_RD_O,
	output logic [9:0]           VEC_ADDR_O,
	input  wire logic [31:0]     VEC_DATA_I,
	input  wire logic            VEC_VALID_I,
	output logic                 SP_LOAD_O,
	output logic [31:0]          SP_VALUE_O,
	output logic                 BRANCH_O,
	output logic [31:0]          HANDLER_PC_O,
	output logic                 STACK_REQ_O,
	input  wire logic            STACK_DONE_I,
	output logic                 UNSTACK_REQ_O,
	input  wire logic            UNSTACK_DONE_I,
	input  wire logic            EXC_RETURN_I,
	output logic [5:0]           EXC_NUM_O
);
	//--------------------------------------------------------------
	// Declarations
	//--------------------------------------------------------------
	nvr_pkg::ctl_state_type state_r, state_nxt;
	logic [47:0]    pend_r, pend_nxt, pend_set, pend_clr, elig;
	logic [31:0]    routed, fixed_line;
	logic [PIN_COUNT-1:0] pin_s;
	logic           nmi_line;
	logic [2:0]     irq_prio [32];
	logic [2:0]     sys_prio [7];
	logic [2:0]     grp_mask, fault_req, esc;
	logic [5:0]     nest_r [NEST_DEPTH];
	logic [5:0]     nest_nxt [NEST_DEPTH];
	logic [SPW-1:0] sp_r, sp_nxt;
	logic [5:0]     cur_r, cur_nxt, best_num;
	logic [3:0]     best_lvl, best_grp, run_lvl, prev_lvl;
	logic           best_valid, arb_bad;
	logic [31:0]    pc_r, pc_nxt, spv_r, spv_nxt;
	logic           branch_r, branch_nxt, spload_r, spload_nxt;

	// Priority level of an exception; smaller is more urgent
	function automatic logic [3:0] exc_level(input logic [5:0] num,
		input logic grp_only);
		logic [2:0] p;
		logic [3:0] lv;
		p  = 3'h0;
		lv = `LVL_THREAD;
		if (num == `EXC_NMI) begin
			lv = `LVL_NMI;
		end else if (num == `EXC_HARD) begin
			lv = `LVL_HARD;
		end else if (num >= `EXC_IRQ_BASE) begin
			p  = irq_prio[5'(num - `EXC_IRQ_BASE)];
			lv = `LVL_PROG_BASE;
		end else begin
			lv = `LVL_PROG_BASE;
			unique case (num)
				`EXC_MEM:       p = sys_prio[0];
				`EXC_BUS:       p = sys_prio[1];
				`EXC_USAGE:     p = sys_prio[2];
				`EXC_SVC:       p = sys_prio[3];
				`EXC_DEBUG:     p = sys_prio[4];
				`EXC_PEND_SERV: p = sys_prio[5];
				`EXC_TICK:      p = sys_prio[6];
				default:        lv = `LVL_THREAD;
			endcase
		end
		// Subpriority bits masked off for preemption decisions
		if (grp_only) begin
			p = p & grp_mask;
		end
		if (lv == `LVL_PROG_BASE) begin
			lv = 4'(lv + {1'b0, p});
		end
		return lv;
	endfunction : exc_level

	//--------------------------------------------------------------
	// Source routing
	//--------------------------------------------------------------
	// Reserved fixed lines are cut so a stray input cannot fire
	assign fixed_line = FIXED_IRQ_I & ~`FIXED_RSVD_MASK;

	genvar gv;
	generate
		for (gv = 0; gv < 32; gv++) begin : g_vec
			irq_source_mux u_mux (
				.sel_i   (nvr_pkg::src_sel_type'(SRC_SEL_I[2*gv +: 2])),
				.fixed_i (fixed_line[gv]),
				.dma_i   ((gv < 16) ? DMA_DONE_BUS_LOW_I[gv % 16]
					: DMA_DONE_BUS_HIGH_I[gv % 16]),
				.array_i (ARRAY_IRQ_I[gv]),
				.line_o  (routed[gv])
			);
			assign irq_prio[gv] = IRQ_PRIO_I[3*gv +: 3];
		end
		for (gv = 0; gv < 7; gv++) begin : g_sys
			assign sys_prio[gv] = SYS_PRIO_I[3*gv +: 3];
		end
	endgenerate

	// Pins come from outside, so they cross two flops first
	pin_sync #(.WIDTH(PIN_COUNT)) u_pin_sync (
		.clk_i (REF_CLK_I),
		.rst_i (RESET_I),
		.ce_i  (CLK_EN_I),
		.d_i   (PIN_I),
		.q_o   (pin_s)
	);
	assign nmi_line = NMI_CONNECT_I & pin_s[NMI_PIN_SEL_I];

	//--------------------------------------------------------------
	// Pending latches and fault escalation
	//--------------------------------------------------------------
	assign grp_mask  = 3'(3'h7 << GROUP_SPLIT_I);
	assign fault_req = {USAGE_FAULT_I, BUS_ERROR_I, MEM_FAULT_I};
	assign run_lvl   = (sp_r == '0) ? `LVL_THREAD
		: exc_level(nest_r[SPW'(sp_r - 1'b1)], 1'b1);
	assign prev_lvl  = (sp_r < SPW'(2)) ? `LVL_THREAD
		: exc_level(nest_r[SPW'(sp_r - 2'h2)], 1'b1);

	// Disabled or too low a fault handler goes to hard fault
	always_comb begin
		for (int f = 0; f < 3; f++) begin
			esc[f] = fault_req[f] & (~FAULT_EN_I[f]
				| (exc_level(6'(`EXC_MEM + f), 1'b1) >= run_lvl));
		end
	end

	// Set wins over the entry clear, so no request is dropped
	always_comb begin
		pend_set = '0;
		pend_set[47:16]         = routed;
		pend_set[`EXC_NMI]      = nmi_line;
		pend_set[`EXC_HARD]     = |esc;
		pend_set[`EXC_MEM]      = fault_req[0] & ~esc[0];
		pend_set[`EXC_BUS]      = fault_req[1] & ~esc[1];
		pend_set[`EXC_USAGE]    = fault_req[2] & ~esc[2];
		pend_set[`EXC_SVC]      = SUPERVISOR_CALL_I;
		pend_set[`EXC_DEBUG]    = DEBUG_MON_I;
		pend_set[`EXC_PEND_SERV] = PENDED_SERVICE_I;
		pend_set[`EXC_TICK]     = SYSTEM_TICK_I;
		pend_nxt = (pend_r & ~pend_clr) | pend_set;
	end
	assign elig = {pend_r[47:16] & IRQ_ENABLE_I, pend_r[15:0]};

	//--------------------------------------------------------------
	// Arbiter
	//--------------------------------------------------------------
	// Strict less-than keeps the lowest number on a tie
	always_comb begin
		best_valid = 1'b0;
		best_num   = `EXC_NONE;
		best_lvl   = `LVL_THREAD;
		for (int i = 1; i < `EXC_COUNT; i++) begin
			if (elig[i] && (!best_valid
				|| exc_level(6'(i), 1'b0) < best_lvl)) begin
				best_valid = 1'b1;
				best_num   = 6'(i);
				best_lvl   = exc_level(6'(i), 1'b0);
			end
		end
		best_grp = exc_level(best_num, 1'b1);
	end

	//--------------------------------------------------------------
	// Entry, tail-chain and exit sequencer
	//--------------------------------------------------------------
	always_comb begin
		state_nxt  = state_r;
		cur_nxt    = cur_r;
		pc_nxt     = pc_r;
		spv_nxt    = spv_r;
		branch_nxt = 1'b0;
		spload_nxt = 1'b0;
		pend_clr   = '0;
		nest_nxt   = nest_r;
		sp_nxt     = sp_r;
		unique case (state_r)
			nvr_pkg::ST_FETCH_SP: begin
				if (VEC_VALID_I) begin
					spv_nxt    = VEC_DATA_I;
					spload_nxt = 1'b1;
					cur_nxt    = `EXC_RESET;
					state_nxt  = nvr_pkg::ST_FETCH_RST;
				end
			end
			nvr_pkg::ST_FETCH_RST: begin
				if (VEC_VALID_I) begin
					pc_nxt     = VEC_DATA_I;
					branch_nxt = 1'b1;
					cur_nxt    = `EXC_NONE;
					state_nxt  = nvr_pkg::ST_IDLE;
				end
			end
			nvr_pkg::ST_IDLE, nvr_pkg::ST_HANDLER: begin
				if (state_r == nvr_pkg::ST_HANDLER && EXC_RETURN_I) begin
					if (best_valid && best_grp < prev_lvl) begin
						// Straight on to the next handler, frame kept
						pend_clr[best_num] = 1'b1;
						nest_nxt[SPW'(sp_r - 1'b1)] = best_num;
						cur_nxt   = best_num;
						state_nxt = nvr_pkg::ST_VECTOR;
					end else begin
						sp_nxt    = SPW'(sp_r - 1'b1);
						state_nxt = nvr_pkg::ST_UNSTACK;
					end
				end else if (best_valid && best_grp < run_lvl
					&& sp_r < SPW'(NEST_DEPTH)) begin
					state_nxt = nvr_pkg::ST_STACK;
				end
			end
			nvr_pkg::ST_STACK: begin
				// Winner is picked only when saving ends
				if (STACK_DONE_I) begin
					if (best_valid) begin
						pend_clr[best_num] = 1'b1;
						nest_nxt[sp_r] = best_num;
						sp_nxt    = SPW'(sp_r + 1'b1);
						cur_nxt   = best_num;
						state_nxt = nvr_pkg::ST_VECTOR;
					end else begin
						state_nxt = nvr_pkg::ST_UNSTACK;
					end
				end
			end
			nvr_pkg::ST_VECTOR: begin
				if (VEC_VALID_I) begin
					pc_nxt     = VEC_DATA_I;
					branch_nxt = 1'b1;
					state_nxt  = nvr_pkg::ST_HANDLER;
				end
			end
			nvr_pkg::ST_UNSTACK: begin
				if (UNSTACK_DONE_I) begin
					if (sp_r == '0) begin
						cur_nxt   = `EXC_NONE;
						state_nxt = nvr_pkg::ST_IDLE;
					end else begin
						cur_nxt   = nest_r[SPW'(sp_r - 1'b1)];
						state_nxt = nvr_pkg::ST_HANDLER;
					end
				end
			end
			default: begin
				state_nxt = nvr_pkg::ST_IDLE;
			end
		endcase
	end

	// Registers, all frozen while the clock enable is low, except that reset still loads them
	always_ff @(posedge REF_CLK_I) begin
		if (RESET_I) begin
			state_r  <= nvr_pkg::ST_FETCH_SP;
			pend_r   <= '0;
			sp_r     <= '0;
			cur_r    <= `EXC_NONE;
			pc_r     <= '0;
			spv_r    <= '0;
			branch_r <= 1'b0;
			spload_r <= 1'b0;
			for (int k = 0; k < NEST_DEPTH; k++) begin
				nest_r[k] <= `EXC_NONE;
			end
		end else if (CLK_EN_I) begin
			state_r  <= state_nxt;
			pend_r   <= pend_nxt;
			sp_r     <= sp_nxt;
			cur_r    <= cur_nxt;
			pc_r     <= pc_nxt;
			spv_r    <= spv_nxt;
			branch_r <= branch_nxt;
			spload_r <= spload_nxt;
			nest_r   <= nest_nxt;
		end
	end

	// Core side outputs
	assign VEC_RD_O      = state_r == nvr_pkg::ST_FETCH_SP
		|| state_r == nvr_pkg::ST_FETCH_RST
		|| state_r == nvr_pkg::ST_VECTOR;
	assign VEC_ADDR_O    = {2'b00, cur_r, 2'b00};
	assign STACK_REQ_O   = state_r == nvr_pkg::ST_STACK;
	assign UNSTACK_REQ_O = state_r == nvr_pkg::ST_UNSTACK;
	assign SP_LOAD_O     = spload_r;
	assign SP_VALUE_O    = spv_r;
	assign BRANCH_O      = branch_r;
	assign HANDLER_PC_O  = pc_r;
	assign EXC_NUM_O     = cur_r;

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	// Independent scan for any better eligible candidate
	always_comb begin
		arb_bad = 1'b0;
		for (int i = 1; i < `EXC_COUNT; i++) begin
			if (elig[i] && (exc_level(6'(i), 1'b0) < best_lvl
				|| (exc_level(6'(i), 1'b0) == best_lvl
				&& 6'(i) < best_num))) begin
				arb_bad = 1'b1;
			end
		end
	end

	default clocking cb @(posedge REF_CLK_I iff CLK_EN_I); endclocking
	default disable iff (RESET_I);

	chk_sp_from_zero: assert property (
		SP_LOAD_O |-> $past(VEC_ADDR_O) == `VEC_OFS_SP
			&& SP_VALUE_O == $past(VEC_DATA_I))
		else $error("stack pointer not loaded from offset zero");
	chk_irq_vector_addr: assert property (
		BRANCH_O && cur_r >= `EXC_IRQ_BASE |-> $past(VEC_ADDR_O)
			== `IRQ_VEC_BASE + {2'b00, 6'(cur_r - `EXC_IRQ_BASE), 2'b00})
		else $error("peripheral vector fetched from wrong offset");
	chk_nmi_wins: assert property (
		state_r == nvr_pkg::ST_STACK && STACK_DONE_I
			&& pend_r[`EXC_NMI] |=> cur_r == `EXC_NMI)
		else $error("pending NMI not taken first");
	chk_fault_escalate: assert property (
		MEM_FAULT_I && !FAULT_EN_I[0] |=> pend_r[`EXC_HARD])
		else $error("disabled fault did not escalate");
	chk_bus_fault_pend: assert property (
		BUS_ERROR_I && !esc[1] |=> pend_r[`EXC_BUS])
		else $error("bus error did not pend bus fault");
	chk_tie_order: assert property (
		best_valid |-> !arb_bad)
		else $error("arbiter skipped a better candidate");
	chk_group_only: assert property (
		state_r == nvr_pkg::ST_HANDLER && !EXC_RETURN_I && best_valid
			&& best_grp >= run_lvl |=> state_r != nvr_pkg::ST_STACK)
		else $error("preemption without higher group priority");
	chk_tail_chain: assert property (
		state_r == nvr_pkg::ST_HANDLER && EXC_RETURN_I && best_valid
			&& best_grp < prev_lvl |=> state_r == nvr_pkg::ST_VECTOR
			&& EXC_NUM_O == $past(best_num) ##1 !UNSTACK_REQ_O)
		else $error("tail-chain did not skip restore");
	chk_auto_stack: assert property (
		state_r == nvr_pkg::ST_IDLE && best_valid |=> STACK_REQ_O)
		else $error("entry without state saving");
	chk_pulse_held: assert property (
		routed[0] |=> pend_r[`EXC_IRQ_BASE])
		else $error("request pulse not latched");
	chk_dma_high: assert property (
		SRC_SEL_I[41:40] == nvr_pkg::SRC_DMA
			|-> routed[20] == DMA_DONE_BUS_HIGH_I[4])
		else $error("vector 20 not on high done bus bit 4");
	chk_nmi_cut: assert property (
		!NMI_CONNECT_I |-> !nmi_line)
		else $error("disconnected NMI still active");

	cov_tail_chain: cover property (
		state_r == nvr_pkg::ST_HANDLER ##1 state_r == nvr_pkg::ST_VECTOR);
	cov_late_arrival: cover property (
		state_r == nvr_pkg::ST_STACK ##1 state_r == nvr_pkg::ST_STACK
			&& best_num != $past(best_num));
	cov_nested: cover property (sp_r == SPW'(2));
endmodule : nested_interrupt_vector_router

// [inc/nvr_map.svh]
// Vector table offsets, exception numbers and priority levels
`ifndef NVR_MAP_SVH
`define NVR_MAP_SVH
`define VEC_OFS_SP      10'h000
`define IRQ_VEC_BASE    10'h040
`define EXC_NONE        6'h00
`define EXC_RESET       6'h01
`define EXC_NMI         6'h02
`define EXC_HARD        6'h03
`define EXC_MEM         6'h04
`define EXC_BUS         6'h05
`define EXC_USAGE       6'h06
`define EXC_SVC         6'h0B
`define EXC_DEBUG       6'h0C
`define EXC_PEND_SERV   6'h0E
`define EXC_TICK        6'h0F
`define EXC_IRQ_BASE    6'h10
`define EXC_COUNT       48
`define LVL_NMI         4'h1
`define LVL_HARD        4'h2
`define LVL_PROG_BASE   4'h3
`define LVL_THREAD      4'hF
`define FIXED_RSVD_MASK 32'h1401_4004
`endif

// [inc/nvr_pkg.sv]
// Types shared by the interrupt router files
package nvr_pkg;
	typedef enum logic [2:0] {
		ST_FETCH_SP  = 3'h0,
		ST_FETCH_RST = 3'h1,
		ST_IDLE      = 3'h2,
		ST_STACK     = 3'h3,
		ST_VECTOR    = 3'h4,
		ST_HANDLER   = 3'h5,
		ST_UNSTACK   = 3'h6
	} ctl_state_type;
	typedef enum logic [1:0] {
		SRC_FIXED = 2'h0,
		SRC_DMA   = 2'h1,
		SRC_ARRAY = 2'h2,
		SRC_NONE  = 2'h3
	} src_sel_type;
endpackage : nvr_pkg

// [hw/pin_sync.sv]
// Two-flop synchroniser for pin inputs
module pin_sync #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic             ce_i,
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);
	logic [WIDTH-1:0] meta_r;

	// First stage is read only by the second stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			q_o    <= '0;
		end else if (ce_i) begin
			meta_r <= d_i;
			q_o    <= meta_r;
		end
	end
endmodule : pin_sync

// [hw/irq_source_mux.sv]
// Source selector for one peripheral interrupt vector
module irq_source_mux (
	input  wire nvr_pkg::src_sel_type sel_i,
	input  wire logic                 fixed_i,
	input  wire logic                 dma_i,
	input  wire logic                 array_i,
	output logic                      line_o
);
	// Pick one of three request lines, or none
	always_comb begin
		unique case (sel_i)
			nvr_pkg::SRC_FIXED: line_o = fixed_i;
			nvr_pkg::SRC_DMA:   line_o = dma_i;
			nvr_pkg::SRC_ARRAY: line_o = array_i;
			nvr_pkg::SRC_NONE:  line_o = 1'b0;
		endcase
	end
endmodule : irq_source_mux

// [sim/core_model.sv]
// Behavioural processor core answering vector fetches and stacking
module core_model (
	input  wire logic        clk_i,
	input  wire logic [1:0]  wait_i,
	input  wire logic        vec_rd_i,
	input  wire logic [9:0]  vec_addr_i,
	input  wire logic        stack_req_i,
	input  wire logic        unstack_req_i,
	output logic      [31:0] vec_data_o,
	output logic             vec_valid_o,
	output logic             stack_done_o,
	output logic             unstack_done_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int   cnt = 0;
	logic busy;
	logic go;
	// ------------------------------------------------------------
	// Answers
	// ------------------------------------------------------------
	// Start values so nothing floats at time zero
	initial begin
		vec_data_o = 32'h0000_0000;
		vec_valid_o = 1'b0;
		stack_done_o = 1'b0;
		unstack_done_o = 1'b0;
	end
	// One-cycle answer after wait_i cycles; data inverts between words
	// so that a stale word can never pass for a fresh one
	always @(posedge clk_i) begin
		#2;
		busy = vec_rd_i || stack_req_i || unstack_req_i;
		go = busy && (cnt >= int'(wait_i));
		cnt = (busy && !go) ? cnt + 1 : 0;
		vec_valid_o = go && vec_rd_i;
		stack_done_o = go && stack_req_i;
		unstack_done_o = go && unstack_req_i;
		// Bit zero set in every word
		vec_data_o = vec_valid_o ? 32'h0800_0001 +
			{18'h0, vec_addr_i, 4'h0} : ~vec_data_o;
	end
endmodule : core_model

// [sim/test_nested_interrupt_vector_router.sv]
// Self-checking bench for the interrupt vector router
module test_nested_interrupt_vector_router;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [31:0] fixed_irq = '0;
	logic [15:0] dma_lo = '0;
	logic [15:0] dma_hi = '0;
	logic [31:0] array_irq = '0;
	logic [63:0] src_sel = '0;
	logic [31:0] irq_en = '1;
	logic [95:0] irq_prio = '0;
	logic [1:0]  split = 2'h0;
	logic [63:0] pins = '0;
	logic        nmi_con = 1'b0;
	logic [5:0]  nmi_sel = 6'h00;
	logic [6:0]  sys_req = '0;
	logic [2:0]  fault_en = 3'h7;
	logic        exc_ret = 1'b0;
	logic [1:0]  wait_cyc = 2'h0;
	logic        vec_rd, vec_valid, sp_load, branch, stack_req, stack_done;
	logic        unstack_req, unstack_done;
	logic [9:0]  vec_addr;
	logic [31:0] vec_data, sp_value, handler_pc;
	logic [5:0]  exc_num;
	int miscompares = 0;
	int total_checks = 0;
	int branches = 0;
	int unstacks = 0;
	// ------------------------------------------------------------
	// Clock, counters and instances
	// ------------------------------------------------------------
	always #12.5 clk = ~clk;
	// Entries and restores seen at the ports
	always @(posedge clk) begin
		branches += (branch === 1'b1);
		unstacks += (unstack_done === 1'b1 && unstack_req === 1'b1);
	end
	nested_interrupt_vector_router nested_interrupt_vector_router_i (
		.REF_CLK_I(clk), .RESET_I(rst), .CLK_EN_I(1'b1),
		.FIXED_IRQ_I(fixed_irq), .DMA_DONE_BUS_LOW_I(dma_lo),
		.DMA_DONE_BUS_HIGH_I(dma_hi), .ARRAY_IRQ_I(array_irq),
		.SRC_SEL_I(src_sel), .IRQ_ENABLE_I(irq_en), .IRQ_PRIO_I(irq_prio),
		.SYS_PRIO_I(21'h0), .GROUP_SPLIT_I(split), .PIN_I(pins),
		.NMI_CONNECT_I(nmi_con), .NMI_PIN_SEL_I(nmi_sel),
		.MEM_FAULT_I(sys_req[0]), .BUS_ERROR_I(sys_req[1]),
		.USAGE_FAULT_I(sys_req[2]), .FAULT_EN_I(fault_en),
		.SUPERVISOR_CALL_I(sys_req[3]), .DEBUG_MON_I(sys_req[4]),
		.PENDED_SERVICE_I(sys_req[5]), .SYSTEM_TICK_I(sys_req[6]),
		.VEC_RD_O(vec_rd), .VEC_ADDR_O(vec_addr), .VEC_DATA_I(vec_data),
		.VEC_VALID_I(vec_valid), .SP_LOAD_O(sp_load),
		.SP_VALUE_O(sp_value), .BRANCH_O(branch),
		.HANDLER_PC_O(handler_pc), .STACK_REQ_O(stack_req),
		.STACK_DONE_I(stack_done), .UNSTACK_REQ_O(unstack_req),
		.UNSTACK_DONE_I(unstack_done), .EXC_RETURN_I(exc_ret),
		.EXC_NUM_O(exc_num));
	core_model core_model_i (
		.clk_i(clk), .wait_i(wait_cyc), .vec_rd_i(vec_rd),
		.vec_addr_i(vec_addr), .stack_req_i(stack_req),
		.unstack_req_i(unstack_req), .vec_data_o(vec_data),
		.vec_valid_o(vec_valid), .stack_done_o(stack_done),
		.unstack_done_o(unstack_done));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	// Word the table holds at a byte offset
	function automatic logic [31:0] word(logic [9:0] ofs);
		return 32'h0800_0001 + {18'h0, ofs, 4'h0};
	endfunction : word
	task automatic tick();
		@(posedge clk);
		#2;
	endtask : tick
	task automatic check(string what, logic [31:0] exp, logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// Bounded wait for an entry, then judge which handler was fetched
	task automatic take(logic [5:0] exc);
		for (int n = 0; n < 200 && branch !== 1'b1; n++) tick();
		check("exc_num", {26'h0, exc}, {26'h0, exc_num});
		check("handler_pc", word({2'h0, exc, 2'h0}), handler_pc);
		tick();
	endtask : take
	task automatic ret();
		exc_ret = 1'b1;
		tick();
		exc_ret = 1'b0;
	endtask : ret
	// Back in thread with nothing outstanding, under a bound
	task automatic idle();
		for (int n = 0; n < 200 && !(exc_num === 6'h00 && vec_rd === 1'b0
			&& stack_req === 1'b0 && unstack_req === 1'b0); n++) tick();
	endtask : idle
	task automatic pulse(logic [31:0] bits);
		fixed_irq = bits;
		tick();
		fixed_irq = '0;
	endtask : pulse
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Reset fetch: stack pointer word first, then reset vector
	task automatic s_reset();
		for (int n = 0; n < 50 && sp_load !== 1'b1; n++) tick();
		check("sp_load", 32'h1, {31'h0, sp_load});
		for (int n = 0; n < 50 && branch !== 1'b1; n++) tick();
		check("sp_value", word(10'h000), sp_value);
		check("reset_pc", word(10'h004), handler_pc);
		tick();
	endtask : s_reset
	// Every vector from one source; other buses all high as decoys
	task automatic route(nvr_pkg::src_sel_type src);
		int b;
		int hit;
		src_sel = {32{src}};
		for (int v = 0; v < 32; v++) begin
			b = branches;
			hit = (src != nvr_pkg::SRC_NONE) && !(src == nvr_pkg::SRC_FIXED
				&& v inside {2, 14, 16, 26, 28});
			fixed_irq = (src == nvr_pkg::SRC_FIXED) ? 32'h1 << v : '1;
			array_irq = (src == nvr_pkg::SRC_ARRAY) ? 32'h1 << v : '1;
			{dma_hi, dma_lo} = (src == nvr_pkg::SRC_DMA) ? 32'h1 << v : '1;
			tick();
			{fixed_irq, dma_lo, dma_hi, array_irq} = '0;
			if (hit != 0) begin
				take(6'(v + 16));
				ret();
			end
			repeat (15) tick();
			idle();
			check("entries", b + hit, branches);
		end
	endtask : route
	// Equal levels, tail chain, changed levels, disabled pending
	task automatic s_prio();
		int u;
		irq_prio[12 +: 3] = 3'h2;
		irq_prio[27 +: 3] = 3'h2;
		pulse(32'h0000_0210);
		take(6'd20);
		u = unstacks;
		ret();
		take(6'd25);
		check("unstacks", u, unstacks);
		ret();
		idle();
		irq_prio[12 +: 3] = 3'h5;
		irq_prio[27 +: 3] = 3'h0;
		pulse(32'h0000_0210);
		take(6'd25);
		ret();
		take(6'd20);
		ret();
		idle();
		irq_en[7] = 1'b0;
		pulse(32'h0000_0080);
		u = branches;
		repeat (15) tick();
		check("disabled", u, branches);
		irq_en[7] = 1'b1;
		take(6'd23);
		ret();
		idle();
	endtask : s_prio
	// Grouping decides preemption; state restored on return
	task automatic s_nest(logic [1:0] sp, logic [5:0] first);
		int u;
		split = sp;
		wait_cyc = 2'h3;
		irq_prio[30 +: 3] = 3'h3;
		irq_prio[36 +: 3] = 3'h1;
		pulse(32'h0000_0400);
		take(6'd26);
		pulse(32'h0000_1000);
		u = unstacks;
		take(first);
		ret();
		if (first == 6'd28) begin
			for (int n = 0; n < 50 && unstacks == u; n++) tick();
			tick();
			check("resumed", 6'd26, exc_num);
			ret();
		end else begin
			// Equal group: no preemption, 28 follows by tail chain
			take(6'd28);
			check("unstacks", u, unstacks);
			ret();
		end
		idle();
		wait_cyc = 2'h0;
	endtask : s_nest
	// Higher request during state saving wins the entry
	task automatic s_late();
		wait_cyc = 2'h3;
		pulse(32'h0000_0400);
		pulse(32'h0000_1000);
		take(6'd28);
		ret();
		take(6'd26);
		ret();
		idle();
		wait_cyc = 2'h0;
	endtask : s_late
	// System exceptions, then a fault whose handler is disabled
	task automatic s_sys();
		logic [5:0] code [7] = '{4, 5, 6, 11, 12, 14, 15};
		for (int i = 0; i < 7; i++) begin
			sys_req = 7'h01 << i;
			tick();
			sys_req = '0;
			take(code[i]);
			ret();
			idle();
		end
		fault_en = 3'h0;
		sys_req = 7'h02;
		tick();
		sys_req = '0;
		take(6'd3);
		ret();
		idle();
	endtask : s_sys
	// Pin routing of the non-maskable input
	task automatic s_nmi();
		int b;
		b = branches;
		nmi_sel = 6'd37;
		wait_cyc = 2'h3;
		pins = '1;
		repeat (6) tick();
		// Selected pin low through both flops before connecting
		pins = ~(64'h1 << 37);
		repeat (3) tick();
		nmi_con = 1'b1;
		repeat (6) tick();
		check("nmi_off", b, branches);
		pins = 64'h1 << 37;
		repeat (2) tick();
		pins = '0;
		take(6'd2);
		ret();
		idle();
		wait_cyc = 2'h0;
	endtask : s_nmi
	task automatic close_out();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		repeat (5) @(posedge clk);
		#2;
		rst = 1'b0;
		s_reset();
		route(nvr_pkg::SRC_FIXED);
		route(nvr_pkg::SRC_DMA);
		route(nvr_pkg::SRC_ARRAY);
		route(nvr_pkg::SRC_NONE);
		src_sel = '0;
		s_prio();
		s_nest(2'h2, 6'd26);
		s_nest(2'h0, 6'd28);
		s_late();
		s_sys();
		s_nmi();
		close_out();
	end
	// Runs out only if an operation hangs
	initial begin
		#(25ns * 30000);
		miscompares++;
		close_out();
	end
endmodule : test_nested_interrupt_vector_router
